// *** common/comparator_control_pkg.sv ***
package comparator_control_pkg;

  localparam int unsigned NUM_COMPARATORS = 2;
  localparam int unsigned ADDR_WIDTH      = 8;
  localparam int unsigned DATA_WIDTH      = 8;
  localparam int unsigned PORT_WIDTH      = 8;
  localparam int unsigned LEVEL_WIDTH     = 8;

  localparam logic [ADDR_WIDTH-1:0] ADDR_COMPARATOR_ONE = 8'hAC;
  localparam logic [ADDR_WIDTH-1:0] ADDR_COMPARATOR_TWO = 8'hAD;
  localparam logic [ADDR_WIDTH-1:0] ADDR_INPUT_DISABLE  = 8'hF6;
  localparam logic [ADDR_WIDTH-1:0] ADDR_PORT_ZERO      = 8'h80;

  localparam logic [DATA_WIDTH-1:0] CONTROL_RESET       = 8'h00;
  localparam logic [PORT_WIDTH-1:0] INPUT_DISABLE_RESET = 8'h00;
  localparam logic [DATA_WIDTH-1:0] READ_IDLE           = 8'h00;
  localparam logic [LEVEL_WIDTH-1:0] INTERNAL_REF_LEVEL = 8'h80;

  localparam int unsigned CLOCK_PERIOD_NS = 10;
  localparam int unsigned SETTLE_TIME_NS  = 10000;
  localparam int unsigned SETTLE_CYCLES   = (SETTLE_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

  typedef struct packed {
    logic [1:0] reserved;
    logic       comparator_enable;
    logic       positive_input_select;
    logic       negative_input_select;
    logic       output_pin_enable;
    logic       synced_comparator_result;
    logic       comparator_change_flag;
  } control_reg_type;

  typedef struct packed {
    logic [ADDR_WIDTH-1:0] addr;
    logic [DATA_WIDTH-1:0] wdata;
    logic                  write;
    logic                  read;
  } bus_request_type;

  typedef enum logic [1:0] {
    SETTLE_OFF  = 2'b00,
    SETTLE_WAIT = 2'b01,
    SETTLE_DONE = 2'b11
  } settle_state_type;
endpackage

// *** rtl/level_synchronizer.sv ***
`timescale 1ns/1ps
module level_synchronizer #(
  parameter int unsigned WIDTH = 8
) (
  input  wire logic             clock_in,
  input  wire logic             sys_rst_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage_one_ff;
  logic [WIDTH-1:0] stage_two_ff;

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      stage_one_ff <= '0;
      stage_two_ff <= '0;
    end else begin
      stage_one_ff <= async_in;
      stage_two_ff <= stage_one_ff;
    end
  end

  assign sync_out = stage_two_ff;
endmodule

// *** rtl/analog_comparator_control.sv ***
`timescale 1ns/1ps
module analog_comparator_control #(
  parameter int unsigned                  LEVEL_W      = comparator_control_pkg::LEVEL_WIDTH,
  parameter int unsigned                  SETTLE_COUNT = comparator_control_pkg::SETTLE_CYCLES,
  parameter logic [LEVEL_W-1:0]           INTERNAL_REF = comparator_control_pkg::INTERNAL_REF_LEVEL
) (
  input  wire logic                                             clock_in,
  input  wire logic                                             sys_rst_in,
  input  wire comparator_control_pkg::bus_request_type          bus_request_in,
  output logic [comparator_control_pkg::DATA_WIDTH-1:0]         read_data_out,
  input  wire logic [1:0][LEVEL_W-1:0]                          first_positive_pin_in,
  input  wire logic [1:0][LEVEL_W-1:0]                          second_positive_pin_in,
  input  wire logic [LEVEL_W-1:0]                               shared_reference_pin_in,
  input  wire logic [comparator_control_pkg::PORT_WIDTH-1:0]    port_zero_pins_in,
  output logic [comparator_control_pkg::PORT_WIDTH-1:0]         port_zero_read_out,
  output logic [comparator_control_pkg::PORT_WIDTH-1:0]         digital_input_disable_out,
  output logic [1:0]                                            comparator_pin_out,
  output logic [1:0]                                            comparator_pin_oe_out,
  output logic [1:0]                                            comparator_settled_out,
  input  wire logic [1:0]                                       comparator_interrupt_enable_in,
  input  wire logic                                             global_interrupt_enable_in,
  input  wire logic [1:0]                                       priority_sufficient_in,
  output logic [1:0]                                            comparator_irq_out
);
  localparam int unsigned NUM    = comparator_control_pkg::NUM_COMPARATORS;
  localparam int unsigned PW     = comparator_control_pkg::PORT_WIDTH;
  localparam int unsigned DW     = comparator_control_pkg::DATA_WIDTH;
  localparam int unsigned SYNC_W = 5 * LEVEL_W + PW;
  localparam int unsigned CNT_W  = $clog2(SETTLE_COUNT + 1);
  localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(SETTLE_COUNT - 1);

  // Positive beats negative strictly; equal levels give zero
  function automatic logic compare_levels(
    input comparator_control_pkg::control_reg_type ctrl,
    input logic [LEVEL_W-1:0]                      first_level,
    input logic [LEVEL_W-1:0]                      second_level,
    input logic [LEVEL_W-1:0]                      ref_level
  );
    logic [LEVEL_W-1:0] pos_level;
    logic [LEVEL_W-1:0] neg_level;
    pos_level = ctrl.positive_input_select ? second_level : first_level;
    neg_level = ctrl.negative_input_select ? INTERNAL_REF : ref_level;
    return pos_level > neg_level;
  endfunction

  function automatic logic [comparator_control_pkg::ADDR_WIDTH-1:0] control_addr(input int unsigned idx);
    return (idx == 0) ? comparator_control_pkg::ADDR_COMPARATOR_ONE : comparator_control_pkg::ADDR_COMPARATOR_TWO;
  endfunction

  // Level codes are treated as slowly varying; a code caught mid-change only
  // shifts the decision by one sample, which the change flag tolerates.
  logic [SYNC_W-1:0]        sync_raw;
  logic [1:0][LEVEL_W-1:0]  first_level;
  logic [1:0][LEVEL_W-1:0]  second_level;
  logic [LEVEL_W-1:0]       ref_level;
  logic [PW-1:0]            port_level;

  level_synchronizer #(
    .WIDTH (SYNC_W)
  ) u_sync (
    .clock_in   (clock_in),
    .sys_rst_in (sys_rst_in),
    .async_in   ({first_positive_pin_in, second_positive_pin_in, shared_reference_pin_in, port_zero_pins_in}),
    .sync_out   (sync_raw)
  );

  assign {first_level, second_level, ref_level, port_level} = sync_raw;

  comparator_control_pkg::control_reg_type  ctrl_ff      [NUM];
  comparator_control_pkg::control_reg_type  nxt_ctrl     [NUM];
  comparator_control_pkg::settle_state_type settle_ff    [NUM];
  comparator_control_pkg::settle_state_type nxt_settle   [NUM];
  logic [CNT_W-1:0]                         settle_cnt_ff  [NUM];
  logic [CNT_W-1:0]                         nxt_settle_cnt [NUM];
  logic [PW-1:0]                            disable_ff;
  logic [PW-1:0]                            nxt_disable;
  logic [DW-1:0]                            read_data_ff;
  logic [DW-1:0]                            nxt_read_data;
  logic [PW-1:0]                            port_read_ff;
  logic [PW-1:0]                            nxt_port_read;
  logic [1:0]                               pin_ff;
  logic [1:0]                               nxt_pin;
  logic [1:0]                               pin_oe_ff;
  logic [1:0]                               nxt_pin_oe;
  logic [1:0]                               irq_ff;
  logic [1:0]                               nxt_irq;
  logic [1:0]                               settled_ff;
  logic [1:0]                               nxt_settled;

  // Start-up timer: results are held at zero until the analog stage settles
  always_comb begin
    for (int i = 0; i < NUM; i++) begin
      nxt_settle[i]     = settle_ff[i];
      nxt_settle_cnt[i] = settle_cnt_ff[i];
      unique case (settle_ff[i])
        comparator_control_pkg::SETTLE_OFF: begin
          nxt_settle_cnt[i] = '0;
          if (ctrl_ff[i].comparator_enable) begin
            nxt_settle[i] = comparator_control_pkg::SETTLE_WAIT;
          end
        end
        comparator_control_pkg::SETTLE_WAIT: begin
          if (!ctrl_ff[i].comparator_enable) begin
            nxt_settle[i] = comparator_control_pkg::SETTLE_OFF;
          end else if (settle_cnt_ff[i] == SETTLE_LAST) begin
            nxt_settle[i] = comparator_control_pkg::SETTLE_DONE;
          end else begin
            nxt_settle_cnt[i] = settle_cnt_ff[i] + CNT_W'(1);
          end
        end
        comparator_control_pkg::SETTLE_DONE: begin
          if (!ctrl_ff[i].comparator_enable) begin
            nxt_settle[i] = comparator_control_pkg::SETTLE_OFF;
          end
        end
        default: begin
          nxt_settle[i] = comparator_control_pkg::SETTLE_OFF;
        end
      endcase
      nxt_settled[i] = (nxt_settle[i] == comparator_control_pkg::SETTLE_DONE);
    end
  end

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      for (int i = 0; i < NUM; i++) begin
        settle_ff[i]     <= comparator_control_pkg::SETTLE_OFF;
        settle_cnt_ff[i] <= '0;
      end
      settled_ff <= '0;
    end else begin
      for (int i = 0; i < NUM; i++) begin
        settle_ff[i]     <= nxt_settle[i];
        settle_cnt_ff[i] <= nxt_settle_cnt[i];
      end
      settled_ff <= nxt_settled;
    end
  end

  // Control registers, result bit and change flag
  always_comb begin
    logic wr_hit;
    logic clear_req;
    logic result;
    wr_hit    = 1'b0;
    clear_req = 1'b0;
    result    = 1'b0;
    for (int i = 0; i < NUM; i++) begin
      nxt_ctrl[i] = ctrl_ff[i];
      wr_hit      = bus_request_in.write && (bus_request_in.addr == control_addr(i));
      clear_req   = wr_hit && !bus_request_in.wdata[0];
      if (wr_hit) begin
        nxt_ctrl[i].comparator_enable     = bus_request_in.wdata[5];
        nxt_ctrl[i].positive_input_select = bus_request_in.wdata[4];
        nxt_ctrl[i].negative_input_select = bus_request_in.wdata[3];
        nxt_ctrl[i].output_pin_enable     = bus_request_in.wdata[2];
      end
      // Reserved bits are never stored so stray writes cannot leak into reads
      nxt_ctrl[i].reserved = 2'b00;
      result = compare_levels(ctrl_ff[i], first_level[i], second_level[i], ref_level);
      if (ctrl_ff[i].comparator_enable && settle_ff[i] == comparator_control_pkg::SETTLE_DONE) begin
        nxt_ctrl[i].synced_comparator_result = result;
      end else begin
        nxt_ctrl[i].synced_comparator_result = 1'b0;
      end
      if (!nxt_ctrl[i].comparator_enable) begin
        nxt_ctrl[i].synced_comparator_result = 1'b0;
        nxt_ctrl[i].comparator_change_flag   = 1'b0;
      end else if (nxt_ctrl[i].synced_comparator_result != ctrl_ff[i].synced_comparator_result) begin
        // A change in the same cycle as a clearing write keeps the flag set
        nxt_ctrl[i].comparator_change_flag = 1'b1;
      end else if (clear_req) begin
        nxt_ctrl[i].comparator_change_flag = 1'b0;
      end
      nxt_pin[i]    = nxt_ctrl[i].synced_comparator_result;
      nxt_pin_oe[i] = nxt_ctrl[i].comparator_enable && nxt_ctrl[i].output_pin_enable;
      nxt_irq[i]    = nxt_ctrl[i].comparator_change_flag && comparator_interrupt_enable_in[i]
                      && global_interrupt_enable_in && priority_sufficient_in[i];
    end
  end

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      for (int i = 0; i < NUM; i++) begin
        ctrl_ff[i] <= comparator_control_pkg::control_reg_type'(comparator_control_pkg::CONTROL_RESET);
      end
      pin_ff    <= '0;
      pin_oe_ff <= '0;
      irq_ff    <= '0;
    end else begin
      for (int i = 0; i < NUM; i++) begin
        ctrl_ff[i] <= nxt_ctrl[i];
      end
      pin_ff    <= nxt_pin;
      pin_oe_ff <= nxt_pin_oe;
      irq_ff    <= nxt_irq;
    end
  end

  // Port zero input gating and register reads
  always_comb begin
    nxt_disable = disable_ff;
    if (bus_request_in.write && bus_request_in.addr == comparator_control_pkg::ADDR_INPUT_DISABLE) begin
      nxt_disable = bus_request_in.wdata;
    end
    nxt_port_read = port_level & ~disable_ff;
    nxt_read_data = comparator_control_pkg::READ_IDLE;
    if (bus_request_in.read) begin
      unique case (bus_request_in.addr)
        comparator_control_pkg::ADDR_COMPARATOR_ONE: nxt_read_data = DW'(ctrl_ff[0]);
        comparator_control_pkg::ADDR_COMPARATOR_TWO: nxt_read_data = DW'(ctrl_ff[1]);
        comparator_control_pkg::ADDR_INPUT_DISABLE:  nxt_read_data = disable_ff;
        comparator_control_pkg::ADDR_PORT_ZERO:      nxt_read_data = port_level & ~disable_ff;
        default:                                     nxt_read_data = comparator_control_pkg::READ_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      disable_ff   <= comparator_control_pkg::INPUT_DISABLE_RESET;
      port_read_ff <= '0;
      read_data_ff <= comparator_control_pkg::READ_IDLE;
    end else begin
      disable_ff   <= nxt_disable;
      port_read_ff <= nxt_port_read;
      read_data_ff <= nxt_read_data;
    end
  end

  assign read_data_out             = read_data_ff;
  assign port_zero_read_out        = port_read_ff;
  assign digital_input_disable_out = disable_ff;
  assign comparator_pin_out        = pin_ff;
  assign comparator_pin_oe_out     = pin_oe_ff;
  assign comparator_settled_out    = settled_ff;
  assign comparator_irq_out        = irq_ff;
endmodule

// *** bench/analog_comparator_control_asserts.sv ***
`timescale 1ns/1ps
module analog_comparator_control_asserts #(
  parameter int unsigned SETTLE_COUNT = 8
) (
  input wire logic                                    clock_in,
  input wire logic                                    sys_rst_in,
  input wire comparator_control_pkg::bus_request_type bus_request_in,
  input wire logic [7:0]                              read_data_out,
  input wire logic [7:0]                              port_zero_read_out,
  input wire logic [7:0]                              digital_input_disable_out,
  input wire logic [1:0]                              comparator_pin_oe_out,
  input wire logic [1:0]                              comparator_settled_out,
  input wire logic [1:0]                              comparator_interrupt_enable_in,
  input wire logic                                    global_interrupt_enable_in,
  input wire logic [1:0]                              priority_sufficient_in,
  input wire logic [1:0]                              comparator_irq_out
);
  logic        en_ff;
  logic        nxt_en;
  int unsigned cnt_ff;
  int unsigned nxt_cnt;
  wire         wr_one = bus_request_in.write && bus_request_in.addr == 8'hAC;
  // Shadow of the enable bit, so the settle time can be measured from the write
  always_comb begin
    nxt_en = wr_one ? bus_request_in.wdata[5] : en_ff;
    nxt_cnt = en_ff ? cnt_ff + 1 : 0;
  end
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      en_ff <= 1'b0;
      cnt_ff <= 0;
    end else begin
      en_ff <= nxt_en;
      cnt_ff <= nxt_cnt;
    end
  end
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);
  sequence s_read(logic [7:0] a);
    bus_request_in.read && bus_request_in.addr == a;
  endsequence
  property p_reserved;
    s_read(8'hAC) |=> read_data_out[7:6] == 2'b00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits read nonzero");
  property p_off_clear;
    s_read(8'hAC) ##1 !read_data_out[5] |-> read_data_out[1:0] == 2'b00;
  endproperty
  a_off_clear: assert property (p_off_clear) else $error("result or flag set while off");
  property p_mask;
    (port_zero_read_out & digital_input_disable_out & $past(digital_input_disable_out)) == 8'h00;
  endproperty
  a_mask: assert property (p_mask) else $error("disabled port bit read as one");
  property p_ddis;
    bus_request_in.write && bus_request_in.addr == 8'hF6 |=>
      digital_input_disable_out == $past(bus_request_in.wdata);
  endproperty
  a_ddis: assert property (p_ddis) else $error("input disable not updated");
  property p_oe;
    wr_one |=> comparator_pin_oe_out[0] == ($past(bus_request_in.wdata[5]) && $past(bus_request_in.wdata[2]));
  endproperty
  a_oe: assert property (p_oe) else $error("pin enable wrong after write");
  property p_irq_one;
    comparator_irq_out[0] |-> $past(global_interrupt_enable_in) && $past(comparator_interrupt_enable_in[0])
      && $past(priority_sufficient_in[0]);
  endproperty
  a_irq_one: assert property (p_irq_one) else $error("irq one without enables");
  property p_irq_two;
    comparator_irq_out[1] |-> $past(global_interrupt_enable_in) && $past(comparator_interrupt_enable_in[1])
      && $past(priority_sufficient_in[1]);
  endproperty
  a_irq_two: assert property (p_irq_two) else $error("irq two without enables");
  property p_settle;
    $rose(comparator_settled_out[0]) |-> cnt_ff + 1 >= SETTLE_COUNT && cnt_ff <= SETTLE_COUNT + 4;
  endproperty
  a_settle: assert property (p_settle) else $error("settle time wrong");
  property p_settle_off;
    wr_one && !bus_request_in.wdata[5] |-> ##[1:2] !comparator_settled_out[0];
  endproperty
  a_settle_off: assert property (p_settle_off) else $error("settled after disable");
endmodule
bind analog_comparator_control analog_comparator_control_asserts #(.SETTLE_COUNT(SETTLE_COUNT)) chk_u (
  .clock_in(clock_in), .sys_rst_in(sys_rst_in), .bus_request_in(bus_request_in), .read_data_out(read_data_out),
  .port_zero_read_out(port_zero_read_out), .digital_input_disable_out(digital_input_disable_out),
  .comparator_pin_oe_out(comparator_pin_oe_out), .comparator_settled_out(comparator_settled_out),
  .comparator_interrupt_enable_in(comparator_interrupt_enable_in),
  .global_interrupt_enable_in(global_interrupt_enable_in), .priority_sufficient_in(priority_sufficient_in),
  .comparator_irq_out(comparator_irq_out));

// *** bench/analog_level_source.sv ***
`timescale 1ns/1ps
module analog_level_source (
  input  wire logic       clock_in,
  input  wire logic [1:0] drop_in,
  output logic [1:0][7:0] first_pin_out,
  output logic [1:0][7:0] second_pin_out,
  output logic [7:0]      ref_pin_out,
  output logic [7:0]      port_pins_out
);
  // Levels straddle the internal reference and the first lies between the two references, so each select bit changes the result in one setting of the other
  always_ff @(posedge clock_in) begin
    for (int i = 0; i < 2; i++) begin
      // Analog pins are fed only from here; their port drivers stay off
      first_pin_out[i] <= drop_in[i] ? 8'h68 : 8'h78;
      second_pin_out[i] <= 8'h88;
    end
    ref_pin_out <= 8'h70;
    port_pins_out <= 8'hFF;
  end
endmodule

// *** bench/analog_comparator_control_tb.sv ***
`timescale 1ns/1ps
module analog_comparator_control_tb;
  logic clock_in = 1'b0;
  logic sys_rst_in = 1'b1;
  comparator_control_pkg::bus_request_type req = '0;
  logic [7:0] rdata, ref_lv, port_lv, port_rd, ddis, cfg;
  logic [1:0][7:0] first_lv, second_lv;
  logic [1:0] pin, oe, settled, irq;
  logic [1:0] drop = 2'b00;
  logic [1:0] ie = 2'b00;
  logic [1:0] pri = 2'b00;
  logic gie = 1'b0;
  logic r;
  int errors = 0;
  int n_checks = 0;
  always #5 clock_in = ~clock_in;
  analog_level_source src_u (.clock_in(clock_in), .drop_in(drop), .first_pin_out(first_lv),
    .second_pin_out(second_lv), .ref_pin_out(ref_lv), .port_pins_out(port_lv));
  analog_comparator_control #(.SETTLE_COUNT(8)) dut_u (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
    .bus_request_in(req), .read_data_out(rdata), .first_positive_pin_in(first_lv),
    .second_positive_pin_in(second_lv), .shared_reference_pin_in(ref_lv), .port_zero_pins_in(port_lv),
    .port_zero_read_out(port_rd), .digital_input_disable_out(ddis), .comparator_pin_out(pin),
    .comparator_pin_oe_out(oe), .comparator_settled_out(settled), .comparator_interrupt_enable_in(ie),
    .global_interrupt_enable_in(gie), .priority_sufficient_in(pri), .comparator_irq_out(irq));
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] want);
    n_checks++;
    if (got !== want) begin
      errors++;
      $display("ERROR %0t got %h want %h", $time, got, want);
    end
  endtask
  task automatic check_pair(input logic [1:0] got, input logic [1:0] want);
    n_checks++;
    if (got !== want) begin
      errors++;
      $display("ERROR %0t got %b want %b", $time, got, want);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_in);
    req <= '{addr: a, wdata: d, write: 1'b1, read: 1'b0};
    @(posedge clock_in);
    req.write <= 1'b0;
  endtask
  // Read data stand only in the cycle after the read, so sample just after that edge
  task automatic rd(input logic [7:0] a, input logic [7:0] want);
    @(posedge clock_in);
    req <= '{addr: a, wdata: 8'h00, write: 1'b0, read: 1'b1};
    @(posedge clock_in);
    req.read <= 1'b0;
    #1 check(rdata, want);
  endtask
  task automatic irq_in(input logic [1:0] e, input logic g, input logic [1:0] p, input logic [1:0] want);
    @(posedge clock_in);
    ie <= e;
    gie <= g;
    pri <= p;
    repeat (3) @(posedge clock_in);
    #1 check_pair(irq, want);
  endtask
  task automatic wait_settled(input int c);
    int i;
    for (i = 0; i < 40 && settled[c] !== 1'b1; i++) @(posedge clock_in);
    if (i == 40) begin
      errors++;
      $display("ERROR %0t settle wait ran out", $time);
      tally_and_finish();
    end
    repeat (4) @(posedge clock_in);
  endtask
  initial begin
    repeat (5) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    rd(8'hAC, 8'h00);
    rd(8'hAD, 8'h00);
    rd(8'hF6, 8'h00);
    rd(8'h5A, 8'h00);
    $display("test reset done");
    wr(8'hF6, 8'h30);
    rd(8'hF6, 8'h30);
    repeat (4) @(posedge clock_in);
    #1 check(port_rd, 8'hCF);
    check(ddis, 8'h30);
    rd(8'h80, 8'hCF);
    $display("test input disable done");
    for (int c = 0; c < 2; c++) begin
      for (int k = 0; k < 8; k++) begin
        cfg = {3'b001, 3'(k), 2'b00};
        r = (k[2] ? 8'h88 : 8'h78) > (k[1] ? comparator_control_pkg::INTERNAL_REF_LEVEL : 8'h70);
        wr(8'hAC | 8'(c), cfg);
        wait_settled(c);
        rd(8'hAC | 8'(c), cfg | {6'h00, r, r});
        check_pair(oe, k[0] ? 2'(1 << c) : 2'b00);
        check_pair(pin, r ? 2'(1 << c) : 2'b00);
        wr(8'hAC | 8'(c), 8'h00);
        rd(8'hAC | 8'(c), 8'h00);
      end
    end
    $display("test configurations done");
    // Interrupts are enabled only after settling and a flag clear, as software must
    wr(8'hAC, 8'h24);
    rd(8'hAC, 8'h24);
    wait_settled(0);
    rd(8'hAC, 8'h27);
    check_pair(pin, 2'b01);
    check_pair(oe, 2'b01);
    wr(8'hAC, 8'h25);
    rd(8'hAC, 8'h27);
    wr(8'hAC, 8'h24);
    rd(8'hAC, 8'h26);
    irq_in(2'b11, 1'b1, 2'b11, 2'b00);
    @(posedge clock_in);
    drop <= 2'b01;
    repeat (6) @(posedge clock_in);
    rd(8'hAC, 8'h25);
    check_pair(irq, 2'b01);
    check_pair(pin, 2'b00);
    irq_in(2'b11, 1'b0, 2'b11, 2'b00);
    irq_in(2'b10, 1'b1, 2'b11, 2'b00);
    irq_in(2'b01, 1'b1, 2'b00, 2'b00);
    wr(8'hAC, 8'h00);
    rd(8'hAC, 8'h00);
    wr(8'hAD, 8'h20);
    wait_settled(1);
    rd(8'hAD, 8'h23);
    wr(8'hAD, 8'h20);
    irq_in(2'b10, 1'b1, 2'b11, 2'b00);
    @(posedge clock_in);
    drop <= 2'b11;
    repeat (6) @(posedge clock_in);
    #1 check_pair(irq, 2'b10);
    $display("test flag and interrupt done");
    tally_and_finish();
  end
endmodule
